//--- debug_pkg.sv
package debug_pkg;
	// ---------------------------------------------------------------
	// command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_BACKGROUND = 8'h90; // no fields
	localparam logic [7:0] CMD_GO = 8'h08; // background only, no fields
	localparam logic [7:0] CMD_READ_STATUS = 8'hE4; // status out
	localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4; // control in
	localparam logic [7:0] CMD_READ_BYTE = 8'hE0; // address in, byte out
	localparam logic [7:0] CMD_WRITE_BYTE = 8'hC0; // address in, byte in
	localparam logic [7:0] CMD_READ_BKPT = 8'hE2; // match word out
	localparam logic [7:0] CMD_WRITE_BKPT = 8'hC2; // match word in
	localparam logic [7:0] CMD_READ_WORD = 8'hE8; // background only
	localparam logic [7:0] CMD_WRITE_WORD = 8'hC8; // background only

	// ---------------------------------------------------------------
	// command shape bits
	// ---------------------------------------------------------------
	localparam int SH_KNOWN = 6;
	localparam int SH_ABM = 5;
	localparam int SH_ADDR = 4;
	localparam int SH_RX16 = 3;
	localparam int SH_RX8 = 2;
	localparam int SH_TX16 = 1;
	localparam int SH_TX8 = 0;

	// ---------------------------------------------------------------
	// debug_status_control layout
	// ---------------------------------------------------------------
	localparam int SC_BG_ENABLE = 7;
	localparam int SC_BG_ACTIVE = 6;
	localparam int SC_BKPT_ENABLE = 5;
	localparam int SC_FORCE_SELECT = 4;
	localparam int SC_CLOCK_SELECT = 3;
	localparam int SC_WAIT_STOP = 2;
	localparam int SC_WAIT_STOP_FLAG = 1;
	localparam int SC_DATA_VALID = 0;
	localparam logic [15:0] BKPT_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// timing, in debug clock ticks
	// ---------------------------------------------------------------
	localparam logic [7:0] SAMPLE_TICKS = 8'h0A; // host bit sampled here
	localparam logic [7:0] HOLD_TICKS = 8'h0D; // target zero held low
	localparam logic [7:0] SPEEDUP_TICKS = 8'h01; // driven high pulse
	localparam logic [7:0] END_TICKS = HOLD_TICKS + SPEEDUP_TICKS;
	localparam logic [7:0] SYNC_MIN_TICKS = 8'h80; // host low for a sync
	localparam logic [7:0] SYNC_DELAY_TICKS = 8'h10; // gap before reply
	localparam logic [7:0] SYNC_PULSE_TICKS = 8'h80; // reply low time
	localparam logic [4:0] LEN_CMD = 5'd8;
	localparam logic [4:0] LEN_ADDR = 5'd16;
	localparam logic [1:0] STRAP_CYCLE = 2'd2; // synchroniser settled
	localparam logic [1:0] ALT_DIV_LAST = 2'd3; // alternate clock is /4
endpackage

//--- debug_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module debug_tick_gen
	import debug_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clock_select,
	output logic tick
);
	// ---------------------------------------------------------------
	// divider
	// ---------------------------------------------------------------
	logic [1:0] div_cnt; // prescale count

	// select high runs at the full rate
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			div_cnt <= 2'd0;
			tick <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == ALT_DIV_LAST) ? 2'd0 : div_cnt + 2'd1;
			tick <= clock_select | (div_cnt == ALT_DIV_LAST);
		end
	end
endmodule
`default_nettype wire

//--- single_wire_background_debug.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - fields travel most significant bit first
// - host starts every bit with falling edge
// - sync request answered by timed low pulse
// - wire level at reset selects background start
// - release by brief driven high speedup
// - delay element gives sixteen debug clocks
// - address sixteen bits, data eight or sixteen
// - status out, control in, same register
// - breakpoint fields load or return match
// - background-only commands need background mode
// - non-intrusive access without halting program
// - breakpoint enable gates match breakpoint requests
// - tag breakpoint marks opcode entering queue
// - force breakpoint finishes instruction, then halts
// - background disabled makes breakpoint software interrupt
// - debug registers reachable only by commands, bg_enable also set by the reset strap
// - eight-bit status, sixteen-bit match register
// - background enable frozen in background mode
// - four status bits are read only
// - clock select writable at any time
module single_wire_background_debug
	import debug_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic debug_wire_in,
	output logic debug_wire_out,
	output logic debug_wire_oe,
	output logic start_in_background,
	input wire logic cpu_background,
	input wire logic cpu_wait_stop,
	output logic enter_background,
	output logic cpu_go,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic module_breakpoint_enable,
	input wire logic module_tag_select,
	input wire logic module_trigger,
	output logic bkpt_tag,
	output logic bkpt_force,
	output logic software_interrupt,
	output logic mem_req,
	output logic mem_write,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack
);
	// ---------------------------------------------------------------
	// types and helpers
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		st_cmd, st_addr, st_data, st_exec, st_load, st_tx,
		st_sync_gap, st_sync_pulse
	} link_state_type;

	// command shape: known, halt only, fields
	function automatic logic [6:0] shape_of(input logic [7:0] code);
		unique case (code)
			CMD_BACKGROUND: shape_of = 7'b1000000;
			CMD_GO: shape_of = 7'b1100000;
			CMD_READ_STATUS: shape_of = 7'b1000001;
			CMD_WRITE_CONTROL: shape_of = 7'b1000100;
			CMD_READ_BYTE: shape_of = 7'b1010001;
			CMD_WRITE_BYTE: shape_of = 7'b1010100;
			CMD_READ_BKPT: shape_of = 7'b1000010;
			CMD_WRITE_BKPT: shape_of = 7'b1001000;
			CMD_READ_WORD: shape_of = 7'b1110010;
			CMD_WRITE_WORD: shape_of = 7'b1111000;
			default: shape_of = 7'b0000000;
		endcase
	endfunction

	// host-to-target data length
	function automatic logic [4:0] rx_len(input logic [6:0] sh);
		rx_len = sh[SH_RX16] ? 5'd16 : (sh[SH_RX8] ? 5'd8 : 5'd0);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	link_state_type state; // protocol position
	logic wire_meta, wire_s, wire_d; // synchroniser, history
	logic [1:0] strap_cnt; // cycles since reset release
	logic bit_active; // inside a host-started bit time
	logic [7:0] tcount; // ticks since the host edge
	logic drive_low, speedup; // target drive during a bit
	logic [7:0] low_cnt; // ticks the wire has stayed low
	logic [7:0] sync_cnt; // ticks inside the sync answer
	logic [4:0] bits_left; // bits left in the current field
	logic [15:0] rx_shift, tx_shift; // field shifters
	logic [7:0] cmd_reg; // command being served
	logic [6:0] shape_reg; // its shape
	logic [15:0] addr_reg, data_reg; // address and data fields
	logic byte_idx, mem_wait; // word half, access in flight
	logic bg_enable, bkpt_enable, force_select, clock_select;
	logic wait_stop_flag, data_valid_flag, wait_stop_d;
	logic [15:0] breakpoint_match; // debug_breakpoint_match
	logic tick; // debug clock enable

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire logic fall = wire_d & ~wire_s;
	wire logic listen = (state != st_sync_gap) && (state != st_sync_pulse);
	wire logic link_io = (state == st_cmd) || (state == st_addr)
		|| (state == st_data) || (state == st_tx);
	wire logic sync_seen = (low_cnt == SYNC_MIN_TICKS);
	wire logic sync_rise = sync_seen & wire_s;
	wire logic start_bit = fall & link_io & ~bit_active & ~sync_seen;
	wire logic sample = bit_active & tick & (tcount == SAMPLE_TICKS);
	wire logic bit_end = bit_active & tick & (tcount == END_TICKS);
	wire logic field_done = bit_end && (bits_left == 5'd1);
	wire logic [6:0] new_shape = shape_of(rx_shift[7:0]);
	wire logic [4:0] data_len = rx_len(shape_reg);
	wire logic [4:0] new_len = rx_len(new_shape);
	wire logic allowed = ~shape_reg[SH_ABM] | cpu_background;
	wire logic is_word = shape_reg[SH_RX16] | shape_reg[SH_TX16];
	wire logic has_tx = shape_reg[SH_TX16] | shape_reg[SH_TX8];
	wire logic load_now = (state == st_load) & allowed;
	wire logic ctrl_write = load_now && (cmd_reg == CMD_WRITE_CONTROL);
	wire logic bkpt_write = load_now && (cmd_reg == CMD_WRITE_BKPT);
	wire logic read_done = mem_wait & mem_ack & ~mem_write
		& (~is_word | byte_idx);
	wire logic status_read = load_now && (cmd_reg == CMD_READ_STATUS);
	// read-only bits come from live state
	wire logic [7:0] status_value = {bg_enable, cpu_background, bkpt_enable,
		force_select, clock_select, cpu_wait_stop, wait_stop_flag,
		data_valid_flag};
	wire logic [15:0] tx_word = !allowed ? 16'hFFFF
		: (cmd_reg == CMD_READ_STATUS) ? {status_value, 8'h00}
		: (cmd_reg == CMD_READ_BKPT) ? breakpoint_match
		: shape_reg[SH_TX8] ? {data_reg[7:0], 8'h00} : data_reg;
	wire logic match_hit = bkpt_enable & fetch_valid
		& (fetch_addr == breakpoint_match);
	wire logic any_hit = (match_hit | (module_breakpoint_enable
		& module_trigger)) & ~cpu_background;
	wire logic use_tag = match_hit ? ~force_select : module_tag_select;
	wire logic next_oe = drive_low | speedup | (state == st_sync_pulse);
	wire logic next_out = speedup
		| ((state == st_sync_pulse) && (sync_cnt == SYNC_PULSE_TICKS));

	// ---------------------------------------------------------------
	// debug clock divider
	// ---------------------------------------------------------------
	debug_tick_gen u_tick (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clock_select(clock_select),
		.tick(tick)
	);

	// ---------------------------------------------------------------
	// pin input and reset strap
	// ---------------------------------------------------------------
	// two flops before any logic
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wire_meta <= 1'b1;
			wire_s <= 1'b1;
			wire_d <= 1'b1;
		end else begin
			wire_meta <= debug_wire_in;
			wire_s <= wire_meta;
			wire_d <= wire_s;
		end
	end

	// strap taken once the synchroniser settles
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			strap_cnt <= 2'd0;
			start_in_background <= 1'b0;
		end else if (strap_cnt != ALT_DIV_LAST) begin
			strap_cnt <= strap_cnt + 2'd1;
			if (strap_cnt == STRAP_CYCLE)
				start_in_background <= ~wire_s;
		end
	end

	// ---------------------------------------------------------------
	// bit timing
	// ---------------------------------------------------------------
	// a long host low aborts any bit for the sync
	always_ff @(posedge clk_sys) begin
		if (!nrst || sync_seen) begin
			bit_active <= 1'b0;
			tcount <= 8'h00;
			drive_low <= 1'b0;
			speedup <= 1'b0;
		end else if (start_bit) begin
			bit_active <= 1'b1;
			tcount <= 8'h00;
			// zero is held low, one released
			drive_low <= (state == st_tx) & ~tx_shift[15];
		end else if (bit_active && tick) begin
			tcount <= tcount + 8'h01;
			if (tcount == HOLD_TICKS) begin
				speedup <= drive_low;
				drive_low <= 1'b0;
			end
			if (tcount == END_TICKS) begin
				bit_active <= 1'b0;
				speedup <= 1'b0;
			end
		end
	end

	// host bits taken at a fixed tick
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			rx_shift <= 16'h0000;
		else if (sample)
			rx_shift <= {rx_shift[14:0], wire_s};
	end

	// wire low time, held at sync threshold
	always_ff @(posedge clk_sys) begin
		if (!nrst || wire_s || !listen)
			low_cnt <= 8'h00;
		else if (tick && !sync_seen)
			low_cnt <= low_cnt + 8'h01;
	end

	// registered pin drive
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			debug_wire_oe <= 1'b0;
			debug_wire_out <= 1'b1;
		end else begin
			debug_wire_oe <= next_oe;
			debug_wire_out <= next_out;
		end
	end

	// ---------------------------------------------------------------
	// command sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state <= st_cmd;
			bits_left <= LEN_CMD;
			cmd_reg <= 8'h00;
			shape_reg <= 7'b0000000;
			addr_reg <= 16'h0000;
			tx_shift <= 16'hFFFF;
			sync_cnt <= 8'h00;
		end else if (sync_rise) begin
			state <= st_sync_gap;
			sync_cnt <= 8'h00;
		end else begin
			unique case (state)
				st_cmd: if (field_done) begin
					cmd_reg <= rx_shift[7:0];
					shape_reg <= new_shape;
					if (!new_shape[SH_KNOWN]) begin
						bits_left <= LEN_CMD;
					end else if (new_shape[SH_ADDR]) begin
						state <= st_addr;
						bits_left <= LEN_ADDR;
					end else if (new_len != 5'd0) begin
						state <= st_data;
						bits_left <= new_len;
					end else begin
						state <= st_exec;
					end
				end else if (bit_end) begin
					bits_left <= bits_left - 5'd1;
				end
				st_addr: if (field_done) begin
					addr_reg <= rx_shift;
					state <= (data_len != 5'd0) ? st_data : st_exec;
					bits_left <= data_len;
				end else if (bit_end) begin
					bits_left <= bits_left - 5'd1;
				end
				st_data: if (field_done) begin
					state <= st_exec;
				end else if (bit_end) begin
					bits_left <= bits_left - 5'd1;
				end
				// work done inside the host delay
				st_exec: if (!allowed || !shape_reg[SH_ADDR]
					|| (mem_wait && mem_ack && (!is_word || byte_idx))) begin
					state <= st_load;
				end
				st_load: begin
					tx_shift <= tx_word;
					state <= has_tx ? st_tx : st_cmd;
					bits_left <= shape_reg[SH_TX16] ? 5'd16 : LEN_CMD;
				end
				// target fields shifted out from the top
				st_tx: if (bit_end) begin
					tx_shift <= {tx_shift[14:0], 1'b1};
					bits_left <= field_done ? LEN_CMD : bits_left - 5'd1;
					if (field_done)
						state <= st_cmd;
				end
				st_sync_gap: if (tick) begin
					sync_cnt <= sync_cnt + 8'h01;
					if (sync_cnt == SYNC_DELAY_TICKS) begin
						state <= st_sync_pulse;
						sync_cnt <= 8'h00;
					end
				end
				st_sync_pulse: if (tick) begin
					sync_cnt <= sync_cnt + 8'h01;
					if (sync_cnt == SYNC_PULSE_TICKS) begin
						state <= st_cmd;
						bits_left <= LEN_CMD;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// memory access
	// ---------------------------------------------------------------
	// bus access while the program keeps running
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_wait <= 1'b0;
			byte_idx <= 1'b0;
			data_reg <= 16'h0000;
		end else begin
			mem_req <= 1'b0;
			if (state == st_data && field_done)
				data_reg <= rx_shift;
			if (state != st_exec) begin
				byte_idx <= 1'b0;
			end else if (allowed && shape_reg[SH_ADDR] && !mem_wait) begin
				// high byte at address, low byte next
				mem_req <= 1'b1;
				mem_wait <= 1'b1;
				mem_write <= data_len != 5'd0;
				mem_addr <= addr_reg + {15'h0000, byte_idx};
				mem_wdata <= (is_word && !byte_idx) ? data_reg[15:8]
					: data_reg[7:0];
			end else if (mem_wait && mem_ack) begin
				mem_wait <= 1'b0;
				byte_idx <= ~byte_idx;
				if (!mem_write && is_word && !byte_idx)
					data_reg[15:8] <= mem_rdata;
				else if (!mem_write)
					data_reg[7:0] <= mem_rdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// debug registers
	// ---------------------------------------------------------------
	// written from the serial link, bg_enable also by the strap
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			bg_enable <= 1'b0;
			bkpt_enable <= 1'b0;
			force_select <= 1'b0;
			clock_select <= 1'b0;
			breakpoint_match <= BKPT_RESET;
		end else begin
			// background start also enables
			if (strap_cnt == STRAP_CYCLE && !wire_s)
				bg_enable <= 1'b1;
			if (ctrl_write && !cpu_background)
				bg_enable <= rx_shift[SC_BG_ENABLE];
			// control field lands in the register
			if (ctrl_write) begin
				bkpt_enable <= rx_shift[SC_BKPT_ENABLE];
				force_select <= rx_shift[SC_FORCE_SELECT];
				clock_select <= rx_shift[SC_CLOCK_SELECT];
			end
			if (bkpt_write)
				breakpoint_match <= data_reg;
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wait_stop_d <= 1'b0;
			wait_stop_flag <= 1'b0;
			data_valid_flag <= 1'b0;
		end else begin
			wait_stop_d <= cpu_wait_stop;
			if (cpu_wait_stop && !wait_stop_d)
				wait_stop_flag <= 1'b1;
			else if (status_read)
				wait_stop_flag <= 1'b0;
			if (read_done)
				data_valid_flag <= 1'b1;
			else if (state == st_cmd && field_done)
				data_valid_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// cpu requests
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			enter_background <= 1'b0;
			cpu_go <= 1'b0;
			bkpt_tag <= 1'b0;
			bkpt_force <= 1'b0;
			software_interrupt <= 1'b0;
		end else begin
			enter_background <= load_now && bg_enable
				&& (cmd_reg == CMD_BACKGROUND);
			cpu_go <= load_now && (cmd_reg == CMD_GO);
			bkpt_tag <= any_hit & bg_enable & use_tag;
			bkpt_force <= any_hit & bg_enable & ~use_tag;
			software_interrupt <= any_hit & ~bg_enable;
		end
	end
endmodule
`default_nettype wire

//--- single_wire_background_debug_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module debug_port_checker (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic debug_wire_oe,
	input wire logic debug_wire_out,
	input wire logic cpu_background,
	input wire logic cpu_go,
	input wire logic fetch_valid,
	input wire logic module_breakpoint_enable,
	input wire logic module_tag_select,
	input wire logic module_trigger,
	input wire logic bkpt_tag,
	input wire logic bkpt_force,
	input wire logic software_interrupt,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// sync reply plus slack
	localparam int MAX_LOW = 520;
	int low_run; // low drive run
	wire logic mod_hit = module_breakpoint_enable && module_trigger && !cpu_background;
	wire logic any_bk = bkpt_tag || bkpt_force || software_interrupt;
	// cleared unless we drive low
	always_ff @(posedge clk_sys) begin
		if (!nrst || !debug_wire_oe || debug_wire_out)
			low_run <= 0;
		else
			low_run <= low_run + 1;
	end
	sequence s_low;
		debug_wire_oe && !debug_wire_out;
	endsequence
	sequence s_kick;
		debug_wire_oe && debug_wire_out;
	endsequence
	property p_release_high;
		$fell(debug_wire_oe) |-> $past(debug_wire_out);
	endproperty
	a_release_high: assert property (p_release_high) else $error("no speedup");
	property p_speedup_short;
		s_low ##1 s_kick |-> ##[1:4] !debug_wire_oe;
	endproperty
	a_speedup_short: assert property (p_speedup_short) else $error("long speedup");
	property p_low_bounded;
		low_run <= MAX_LOW;
	endproperty
	a_low_bounded: assert property (p_low_bounded) else $error("long low");
	property p_go_in_bg;
		cpu_go |-> $past(cpu_background);
	endproperty
	a_go_in_bg: assert property (p_go_in_bg) else $error("go outside halt");
	property p_req_pulse;
		mem_req |=> !mem_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("long request");
	property p_mem_stable;
		$past(nrst) && !mem_req |-> $stable(mem_addr) && $stable(mem_wdata);
	endproperty
	a_mem_stable: assert property (p_mem_stable) else $error("memory moved");
	property p_bg_quiet;
		any_bk |-> $past(!cpu_background);
	endproperty
	a_bg_quiet: assert property (p_bg_quiet) else $error("halted hit");
	property p_mod_fires;
		$past(mod_hit) |-> any_bk;
	endproperty
	a_mod_fires: assert property (p_mod_fires) else $error("trigger lost");
	property p_mod_kind;
		$past(mod_hit && !fetch_valid) |-> software_interrupt
			|| (bkpt_tag == $past(module_tag_select) && bkpt_force != $past(module_tag_select));
	endproperty
	a_mod_kind: assert property (p_mod_kind) else $error("wrong kind");
	property p_one_kind;
		any_bk |-> $onehot({bkpt_tag, bkpt_force, software_interrupt});
	endproperty
	a_one_kind: assert property (p_one_kind) else $error("kinds overlap");
endmodule
`default_nettype wire

//--- debug_host_pod.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host pod model
// ----------------------------------------
module debug_host_pod (
	input wire logic clk_sys,
	input wire logic wire_level,
	output logic pod_oe,
	output logic pod_out
);
	int div = 4; // clocks per tick
	initial begin
		pod_oe = 1'b0;
		pod_out = 1'b0;
	end
	// one bit; a one is a short low
	task automatic bit_time(input logic val, output logic seen);
		int rel;
		rel = val ? 1 : 12 * div + 4;
		for (int c = 0; c < 16 * div + 8; c++) begin
			@(posedge clk_sys);
			#2;
			pod_oe = (c <= rel);
			pod_out = (c == rel);
			if (c == 8 * div + 4)
				seen = wire_level;
		end
	endtask
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		logic b;
		rx = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			bit_time(tx[i], b);
			rx = {rx[14:0], b};
		end
	endtask
	task automatic pause();
		repeat (20 * div) @(posedge clk_sys);
	endtask
	task automatic sync(output int len);
		@(posedge clk_sys);
		#2;
		pod_oe = 1'b1;
		pod_out = 1'b0;
		repeat (130 * div) @(posedge clk_sys);
		#2;
		pod_out = 1'b1;
		@(posedge clk_sys);
		#2;
		pod_oe = 1'b0;
		pod_out = 1'b0;
		len = 0;
		for (int c = 0; c < 200 * div; c++) begin
			@(posedge clk_sys);
			#2;
			if (!wire_level)
				len++;
		end
	endtask
endmodule
`default_nettype wire

//--- single_wire_background_debug_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// debug controller bench
// ----------------------------------------
module single_wire_background_debug_tb
	import debug_pkg::*;
;
	logic clk_sys = 1'b0, nrst = 1'b0, cpu_background = 1'b0, cpu_wait_stop = 1'b0;
	logic fetch_valid = 1'b0, mem_ack = 1'b0, module_trigger = 1'b0;
	logic module_breakpoint_enable = 1'b0, module_tag_select = 1'b0;
	logic [15:0] fetch_addr = 16'h0000;
	logic [7:0] mem_rdata = 8'h00;
	logic debug_wire_out, debug_wire_oe, start_in_background, enter_background, cpu_go;
	logic bkpt_tag, bkpt_force, software_interrupt, mem_req, mem_write;
	logic [15:0] mem_addr, r, a, d;
	logic [7:0] mem_wdata;
	logic pod_oe, pod_out, wire_level;
	logic [2:0] bk_seen = 3'b000; // tag, force, soft interrupt
	int bad_count, checked, go_cnt, bg_cnt, cycles, n;
	integer seed;
	// pullup, any low driver wins
	assign wire_level = (debug_wire_oe ? debug_wire_out : 1'b1) & (pod_oe ? pod_out : 1'b1);
	single_wire_background_debug single_wire_background_debug_inst (.clk_sys(clk_sys),
		.nrst(nrst), .debug_wire_in(wire_level), .debug_wire_out(debug_wire_out),
		.debug_wire_oe(debug_wire_oe), .start_in_background(start_in_background),
		.cpu_background(cpu_background), .cpu_wait_stop(cpu_wait_stop),
		.enter_background(enter_background), .cpu_go(cpu_go), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .module_breakpoint_enable(module_breakpoint_enable),
		.module_tag_select(module_tag_select), .module_trigger(module_trigger),
		.bkpt_tag(bkpt_tag), .bkpt_force(bkpt_force), .software_interrupt(software_interrupt),
		.mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	debug_host_pod pod_inst (.clk_sys(clk_sys), .wire_level(wire_level), .pod_oe(pod_oe),
		.pod_out(pod_out));
	initial forever #10 clk_sys = ~clk_sys;
	function automatic logic [7:0] mbyte(input logic [15:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h5A;
	endfunction
	// memory acks a cycle later; idle data toggles
	always @(posedge clk_sys) begin
		mem_ack <= mem_req;
		mem_rdata <= mem_req ? mbyte(mem_addr) : ~mem_rdata;
		bk_seen <= bk_seen | {bkpt_tag, bkpt_force, software_interrupt};
		if (cpu_go)
			go_cnt <= go_cnt + 1;
		if (enter_background)
			bg_cnt <= bg_cnt + 1;
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] code, input logic [15:0] ad, input int na,
		input logic [15:0] dat, input int nd, input int nr);
		logic [15:0] junk;
		pod_inst.xfer({8'h00, code}, 8, junk);
		if (na > 0)
			pod_inst.xfer(ad, 16, junk);
		if (nd > 0)
			pod_inst.xfer(dat, nd, junk);
		pod_inst.pause();
		r = 16'hFFFF;
		if (nr > 0)
			pod_inst.xfer(16'hFFFF, nr, r);
	endtask
	task automatic ctl(input logic [7:0] v);
		cmd(CMD_WRITE_CONTROL, 16'h0000, 0, {8'h00, v}, 8, 0);
		pod_inst.div = v[SC_CLOCK_SELECT] ? 1 : 4;
	endtask
	task automatic stat(input string what, input logic [7:0] exp);
		cmd(CMD_READ_STATUS, 16'h0000, 0, 16'h0000, 0, 8);
		chk(what, {8'h00, exp}, r);
	endtask
	task automatic do_reset(input logic lvl);
		@(posedge clk_sys);
		#2;
		pod_inst.pod_oe = !lvl;
		nrst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#2 nrst = 1'b1;
		repeat (6) @(posedge clk_sys);
		#2 pod_inst.pod_oe = 1'b0;
		pod_inst.div = 4;
		chk("start", {15'h0, !lvl}, {15'h0, start_in_background});
	endtask
	task automatic fire(input logic [15:0] fa, input logic mt, input logic [2:0] exp);
		@(posedge clk_sys);
		#2;
		bk_seen = 3'b000;
		fetch_valid = !mt;
		fetch_addr = fa;
		module_trigger = mt;
		@(posedge clk_sys);
		#2;
		fetch_valid = 1'b0;
		module_trigger = 1'b0;
		repeat (3) @(posedge clk_sys);
		#2;
		chk("bkpt", {13'h0, exp}, {13'h0, bk_seen});
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		seed = 57950;
		do_reset(1'b0);
		stat("strap", 8'h80);
		do_reset(1'b1);
		stat("reset", 8'h00);
		cpu_wait_stop = 1'b1;
		ctl(8'hFF);
		stat("ro bits", 8'hBE);
		cpu_wait_stop = 1'b0;
		stat("flag", 8'hB8);
		ctl(8'h00);
		$display("registers done");
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 16'hFFFF : 16'($random(seed));
			d = (i == 1) ? 16'h0000 : 16'($random(seed));
			cmd(CMD_WRITE_BKPT, a, 0, d, 16, 0);
			cmd(CMD_READ_BKPT, a, 0, a, 0, 16);
			chk("match", d, r);
			cmd(CMD_WRITE_BYTE, a, 16, {8'h00, d[7:0]}, 8, 0);
			chk("wdata", {7'h00, 1'b1, d[7:0]}, {7'h00, mem_write, mem_wdata});
			chk("waddr", a, mem_addr);
			cmd(CMD_READ_BYTE, a, 16, a, 0, 8);
			chk("read byte", {8'h00, mbyte(a)}, r);
		end
		cmd(CMD_READ_WORD, a + 16'h2, 16, 16'h0000, 0, 16);
		chk("refused word", 16'hFFFF, r);
		chk("no access", a, mem_addr);
		cmd(CMD_GO, a, 0, a, 0, 0);
		cmd(CMD_BACKGROUND, a, 0, a, 0, 0);
		chk("refused go", 16'h0000, 16'(go_cnt + bg_cnt));
		ctl(8'h80);
		cmd(CMD_BACKGROUND, a, 0, a, 0, 0);
		chk("enter", 16'h0001, 16'(bg_cnt));
		cpu_background = 1'b1;
		ctl(8'h00);
		stat("held", 8'hC0);
		cmd(CMD_READ_WORD, a, 16, 16'h0000, 0, 16);
		chk("read word", {mbyte(a), mbyte(a + 16'h1)}, r);
		cmd(CMD_GO, a, 0, a, 0, 0);
		chk("go", 16'h0001, 16'(go_cnt));
		cpu_background = 1'b0;
		$display("commands done");
		cmd(CMD_WRITE_BKPT, a, 0, 16'h1234, 16, 0);
		ctl(8'hB0);
		fire(16'h1234, 1'b0, 3'b010);
		fire(16'h1235, 1'b0, 3'b000);
		ctl(8'hA0);
		fire(16'h1234, 1'b0, 3'b100);
		module_breakpoint_enable = 1'b1;
		module_tag_select = 1'b1;
		fire(16'h0000, 1'b1, 3'b100);
		module_tag_select = 1'b0;
		fire(16'h0000, 1'b1, 3'b010);
		ctl(8'h20);
		fire(16'h1234, 1'b0, 3'b001);
		module_breakpoint_enable = 1'b0;
		fire(16'h0000, 1'b1, 3'b000);
		$display("breakpoints done");
		pod_inst.sync(n);
		chk("sync", 16'h0001, {15'h0, (n >= 508 && n <= 516)});
		$display("sync done");
		print_verdict();
	end
endmodule
bind single_wire_background_debug debug_port_checker checker_inst (.clk_sys(clk_sys),
	.nrst(nrst), .debug_wire_oe(debug_wire_oe), .debug_wire_out(debug_wire_out),
	.cpu_background(cpu_background), .cpu_go(cpu_go), .fetch_valid(fetch_valid),
	.module_breakpoint_enable(module_breakpoint_enable), .module_tag_select(module_tag_select),
	.module_trigger(module_trigger), .bkpt_tag(bkpt_tag), .bkpt_force(bkpt_force),
	.software_interrupt(software_interrupt), .mem_req(mem_req), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata));
`default_nettype wire
